// *** verification/dadc_capture_model.sv ***
// Capture logic model: latches converter words as receiving logic would.
// Assumes converter outputs change only on rising edges of clk.
module dadc_capture_model
  import dadc_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // Converter side
  input  wire logic              sample_clock,
  input  wire logic              mode,
  input  wire logic [WORD_W-1:0] bus1,
  input  wire logic [WORD_W-1:0] bus2,
  input  wire logic              strobe,
  input  wire logic              settled,
  // Captured pair
  output logic      [WORD_W-1:0] cap_first,
  output logic      [WORD_W-1:0] cap_second,
  output logic      [15:0]       cap_count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prev_sc;
  logic prev_st;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prev_sc   <= 1'b0;
      prev_st   <= 1'b0;
      cap_count <= 16'h0000;
      cap_first  <= '0;
      cap_second <= '0;
    end
    else
    begin
      prev_sc <= sample_clock;
      prev_st <= strobe;
      if (settled)
      begin
        // strobe edges, not clock edges, pick the word
        if (!mode && strobe && !prev_st)
          cap_first <= bus1;
        if (!mode && !strobe && prev_st)
        begin
          cap_second <= bus1;
          cap_count  <= cap_count + 16'h0001;
        end
        // Parallel words are stable at the sampling fall
        if (mode && prev_sc && !sample_clock)
        begin
          cap_first  <= bus1;
          cap_second <= bus2;
          cap_count  <= cap_count + 16'h0001;
        end
      end
    end
  end
endmodule

// *** verification/tb_dual_adc_output_timing.sv ***
// Bench for the dual converter: register bus, output timing, sleep pins.
// Assumes the capture model beside the design and a 100 MHz clock.
module tb_dual_adc_output_timing
  import dadc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // A short deep wake keeps the run brief
  localparam int DEEP = 20;
  localparam int NV   = 5;
  logic                   clk     = 1'b0;
  logic                   rst_b   = 1'b0;
  logic signed [IN_W-1:0] ain1    = '0;
  logic signed [IN_W-1:0] ain2    = '0;
  logic                   deep_pin  = 1'b0;
  logic                   light_pin = 1'b0;
  logic                   mode    = 1'b1;
  logic                   rng     = 1'b0;
  logic [ADDR_W-1:0]      awaddr  = '0;
  logic [ADDR_W-1:0]      araddr  = '0;
  logic [31:0]            wdata   = '0;
  logic                   awvalid = 1'b0;
  logic                   wvalid  = 1'b0;
  logic                   bready  = 1'b0;
  logic                   arvalid = 1'b0;
  logic                   rready  = 1'b0;
  logic                   sc, strobe, settled, awready, wready, bvalid, arready, rvalid;
  logic [1:0]             bresp, rresp;
  logic [31:0]            rdata;
  logic [WORD_W-1:0]      bus1, bus2, cap1, cap2;
  logic [15:0]            ccount;
  int                     mismatches = 0;
  int                     num_checks = 0;
  int                     tv [NV] = '{700, 300, 766, 1100, 511};
  logic                   tr [NV] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
  `define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("CHECK FAILED %s exp=%0h got=%0h", nm, e, g); end end
  always #5 clk = ~clk;
  dadc_top #(.DEEP_WAKE_CYCLES(DEEP)) dut (
    .clk(clk), .ce(1'b1), .rst_b(rst_b),
    .first_analog_in(ain1), .second_analog_in(ain2),
    .power_down_pin(deep_pin), .standby_pin(light_pin),
    .output_mode_select(mode), .range_select_pin(rng),
    .sample_clock(sc), .first_channel_output_bus(bus1),
    .second_channel_output_bus(bus2), .channel_select_strobe(strobe),
    .conversion_settled(settled),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );
  dadc_capture_model cap (
    .clk(clk), .rst_b(rst_b), .sample_clock(sc), .mode(mode), .bus1(bus1),
    .bus2(bus2), .strobe(strobe), .settled(settled), .cap_first(cap1),
    .cap_second(cap2), .cap_count(ccount)
  );
  function automatic logic [WORD_W-1:0] code(input logic signed [IN_W-1:0] v, input logic r);
    logic signed [IN_W-1:0] s;
    s = r ? (v >>> 1) : v;
    if (s > LIM_POS)
      return POS_FS;
    if (s < LIM_NEG)
      return NEG_FS;
    return s[WORD_W-1:0];
  endfunction
  // Handshake seen high at a falling edge completes at the next rise
  task automatic acc(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                     input logic [1:0] er, input logic ck);
    logic       aw, w, ar, done;
    logic [1:0] r;
    logic [31:0] q;
    @(posedge clk);
    awaddr  <= a;
    araddr  <= a;
    wdata   <= d;
    awvalid <= wr;
    wvalid  <= wr;
    bready  <= wr;
    arvalid <= !wr;
    rready  <= !wr;
    done = 1'b0;
    while (!done)
    begin
      @(negedge clk);
      aw = awvalid && awready;
      w = wvalid && wready;
      ar = arvalid && arready;
      done = wr ? bvalid : rvalid;
      r = wr ? bresp : rresp;
      q = rdata;
      @(posedge clk);
      if (aw)
        awvalid <= 1'b0;
      if (w)
        wvalid <= 1'b0;
      if (ar)
        arvalid <= 1'b0;
      if (done)
      begin
        bready <= 1'b0;
        rready <= 1'b0;
      end
    end
    `CHK("resp", er, r);
    if (ck && !wr)
      `CHK("rdata", d, q);
  endtask
  task automatic wake(output int n);
    n = 0;
    while (settled !== 1'b1 && n < 400)
    begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic sleep(input logic use_deep, output int n);
    logic s0;
    @(posedge clk);
    deep_pin  <= use_deep;
    light_pin <= !use_deep;
    repeat (4) @(negedge clk);
    s0 = sc;
    repeat (8)
    begin
      @(negedge clk);
      `CHK("frozen", s0, sc);
      `CHK("asleep", 1'b0, settled);
    end
    @(posedge clk);
    deep_pin  <= 1'b0;
    light_pin <= 1'b0;
    wake(n);
  endtask
  // Step both inputs just after a sampling fall, count to each new word
  task automatic latency(input logic m);
    int d1, d2;
    @(posedge clk);
    mode <= m;
    ain1 <= '0;
    ain2 <= '0;
    repeat (24) @(posedge clk);
    @(negedge sc);
    @(posedge clk);
    ain1 <= 12'sh0A0;
    ain2 <= 12'sh050;
    @(negedge sc);
    d1 = 0;
    d2 = 0;
    for (int n = 1; n <= 20; n++)
    begin
      @(negedge clk);
      if (d1 == 0 && bus1 === 10'h0A0)
        d1 = n;
      if (d2 == 0 && (m ? bus2 : bus1) === 10'h050)
        d2 = n;
      if (n == 12)
        `CHK("strobe", !m, strobe);
    end
    `CHK("lat_first", 8'h0C, d1);
    `CHK("lat_second", m ? 8'h0C : 8'h0E, d2);
  endtask
  task automatic print_verdict();
    if (mismatches == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    int          n;
    logic [15:0] c;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    `CHK("settled_rst", 1'b0, settled);
    acc(1'b0, OFF_CTRL, 32'h1, RESP_OKAY, 1'b1);
    acc(1'b0, 4'hC, 32'h0, RESP_SLVERR, 1'b1);
    acc(1'b1, 4'hC, 32'h5, RESP_SLVERR, 1'b0);
    acc(1'b1, OFF_DATA, 32'h5, RESP_OKAY, 1'b0);
    wake(n);
    `CHK("deep_wake", 1'b1, n <= DEEP + 4);
    latency(1'b1);
    latency(1'b0);
    for (int m = 0; m < 2; m++)
      for (int i = 0; i < NV; i++)
      begin
        @(posedge clk);
        mode <= m[0];
        rng  <= tr[i];
        ain1 <= IN_W'(tv[i]);
        ain2 <= IN_W'(-tv[i]);
        repeat (30) @(negedge clk);
        `CHK("word_first", code(IN_W'(tv[i]), tr[i]), cap1);
        `CHK("word_second", code(IN_W'(-tv[i]), tr[i]), cap2);
      end
    c = ccount;
    repeat (40) @(negedge clk);
    `CHK("rate", c + 16'h000A, ccount);
    sleep(1'b0, n);
    `CHK("standby_wake", 1'b1, n <= STANDBY_WAKE_CLKS + 4);
    sleep(1'b1, n);
    `CHK("power_wake", 1'b1, n <= DEEP + 4);
    @(posedge clk);
    ain1 <= 12'sh123;
    ain2 <= 12'shE10;
    acc(1'b1, OFF_CTRL, 32'h0, RESP_OKAY, 1'b0);
    repeat (8) acc(1'b0, OFF_DATA, 32'h0, RESP_OKAY, 1'b0);
    acc(1'b1, OFF_STATUS, 32'h10, RESP_OKAY, 1'b0);
    acc(1'b0, OFF_STATUS, 32'h7, RESP_OKAY, 1'b1);
    acc(1'b1, OFF_CTRL, 32'h1, RESP_OKAY, 1'b0);
    repeat (60) @(posedge clk);
    acc(1'b0, OFF_STATUS, 32'h1B, RESP_OKAY, 1'b1);
    acc(1'b1, OFF_CTRL, 32'h0, RESP_OKAY, 1'b0);
    repeat (8) acc(1'b0, OFF_DATA, 32'h02100123, RESP_OKAY, 1'b1);
    acc(1'b0, OFF_DATA, 32'h0, RESP_OKAY, 1'b1);
    acc(1'b0, OFF_STATUS, 32'h17, RESP_OKAY, 1'b1);
    acc(1'b1, OFF_STATUS, 32'h10, RESP_OKAY, 1'b0);
    acc(1'b0, OFF_STATUS, 32'h7, RESP_OKAY, 1'b1);
    print_verdict();
  end
  // The whole run takes under a thousand cycles
  initial
  begin
    #50000;
    mismatches++;
    print_verdict();
  end
endmodule

// *** verilog/dadc_fifo.sv ***
// Flop-based FIFO holding converted word pairs.
// Assumes DEPTH is a power of two; push and pop share one clock.
module dadc_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 8
)(
  // Clock, enable and reset
  input wire logic clk,
  input wire logic ce,
  input wire logic rst_b,
  // Both sides
  dadc_fifo_if.fifo port
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  wire              push = port.in_valid && port.in_ready;
  wire              pop  = port.out_valid && port.out_ready;

  assign port.in_ready  = count != FULL_CNT;
  assign port.out_valid = count != '0;
  assign port.out_data  = mem[rd_ptr];

  // Data needs no reset; only pointers and count carry control state
  always_ff @(posedge clk)
  begin
    if (ce && push)
      mem[wr_ptr] <= port.in_data;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else if (ce)
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// *** verilog/dadc_fifo_if.sv ***
// Link between the converter core and its capture buffer.
// Assumes the core drives the fill side and the drain side's ready.
interface dadc_fifo_if #(
  parameter int WIDTH = 20
);
  logic             in_valid;
  logic             in_ready;
  logic [WIDTH-1:0] in_data;
  logic             out_valid;
  logic             out_ready;
  logic [WIDTH-1:0] out_data;
  modport core (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
  modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
endinterface

// *** verilog/dadc_pkg.sv ***
// Shared constants and types for the dual converter output block.
// Assumes a single 100 MHz clock; all counts but HALF_CLKS derive from it here.
package dadc_pkg;
  // Clock
  localparam int CLK_MHZ       = 100;
  localparam int CLK_PERIOD_NS = 10;
  // Word formats
  localparam int WORD_W = 10;
  localparam int IN_W   = 12;
  localparam int NCH    = 2;
  localparam logic signed [IN_W-1:0] LIM_POS = 12'sh1FF;
  localparam logic signed [IN_W-1:0] LIM_NEG = 12'shE00;
  localparam logic [WORD_W-1:0] POS_FS = 10'h1FF;
  localparam logic [WORD_W-1:0] NEG_FS = 10'h200;
  // Sampling clock, latency in half periods
  localparam int MAX_MSPS        = 45;
  localparam int MIN_SAMPLE_CLKS = (CLK_MHZ + MAX_MSPS - 1) / MAX_MSPS;
  localparam int HALF_CLKS       = 2;
  localparam logic [1:0] HALF_LAST = 2'(HALF_CLKS - 1);
  localparam int LAT_HALVES_I = 5;
  localparam int LAT_HALVES_Q = 6;
  localparam int PIPE_D       = 7;
  // Output delay after a sampling clock edge
  localparam int OUT_DELAY_NS   = 16;
  localparam int OUT_DELAY_RAW  = OUT_DELAY_NS / CLK_PERIOD_NS;
  localparam int OUT_DELAY_CLKS = (OUT_DELAY_RAW < 1) ? 1 : OUT_DELAY_RAW;
  // Wake-up times
  localparam int WAIT_W        = 17;
  localparam int STANDBY_WAKE_NS   = 800;
  localparam int STANDBY_WAKE_CLKS = (STANDBY_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEEP_WAKE_NS  = 1000000;
  localparam int DEEP_WAKE_CLKS = DEEP_WAKE_NS / CLK_PERIOD_NS;
  // Register map, byte addresses
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFF_CTRL   = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_DATA   = 4'h8;
  localparam int CTRL_CAPTURE_BIT = 0;
  localparam logic CTRL_CAPTURE_RST = 1'b1;
  localparam int STAT_SETTLED = 0;
  localparam int STAT_AWAKE   = 1;
  localparam int STAT_EMPTY   = 2;
  localparam int STAT_FULL    = 3;
  localparam int STAT_OVERRUN = 4;
  localparam int DATA_Q_LSB   = 16;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Capture buffer
  localparam int FIFO_W     = NCH * WORD_W;
  localparam int FIFO_DEPTH = 8;
  // Power state, Gray along off, wake, run
  typedef enum logic [1:0] {
    ST_OFF  = 2'h0,
    ST_WAKE = 2'h1,
    ST_RUN  = 2'h3
  } dadc_pwr_t;
endpackage

// *** verilog/dadc_top.sv ***
// Digital side of a dual 10-bit sampling converter with AXI4-Lite access.
// Assumes synchronous pins, one clock, and analog inputs given as signed
// codes where +-512 spans the reference with the range pin low.
// Behaviour
// - Both channels sampled together on falling edge
// - Ten-bit words, at most 45 MSPS
// - Parallel mode: both buses update after rise
// - Multiplexed: first on rise, second on fall
// - Parallel latency 2.5 sampling cycles
// - Multiplexed latency 2.5 and 3.0 cycles
// - One new result every sampling cycle
// - Convert only with both sleep pins low
// - Below negative limit gives negative full scale
// - Above positive limit gives positive full scale
// - Range pin doubles the input span
// - Mode pin low multiplexed, high parallel
// - Standby wake within 800 ns
// - Power-down wake within 1 ms
//
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
module dadc_top
  import dadc_pkg::*;
#(
  parameter int DEEP_WAKE_CYCLES = DEEP_WAKE_CLKS
)(
  // Clock, enable and reset
  input  wire logic                   clk,
  input  wire logic                   ce,
  input  wire logic                   rst_b,
  // Converter inputs
  input  wire logic signed [IN_W-1:0] first_analog_in,
  input  wire logic signed [IN_W-1:0] second_analog_in,
  input  wire logic                   power_down_pin,
  input  wire logic                   standby_pin,
  input  wire logic                   output_mode_select,
  input  wire logic                   range_select_pin,
  // Converter outputs
  output logic                        sample_clock,
  output logic [WORD_W-1:0]           first_channel_output_bus,
  output logic [WORD_W-1:0]           second_channel_output_bus,
  output logic                        channel_select_strobe,
  output logic                        conversion_settled,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0]      s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [ADDR_W-1:0]      s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready
);
  localparam int LAT_I_CLKS = LAT_HALVES_I * HALF_CLKS + OUT_DELAY_CLKS + 1;
  localparam int LAT_Q_CLKS = LAT_HALVES_Q * HALF_CLKS + OUT_DELAY_CLKS + 1;
  localparam logic [WAIT_W-1:0] STANDBY_LAST = WAIT_W'(STANDBY_WAKE_CLKS - 1);
  localparam logic [WAIT_W-1:0] DEEP_LAST = WAIT_W'(DEEP_WAKE_CYCLES - 1);

  dadc_pwr_t               st;
  dadc_pwr_t               next_st;
  logic [WAIT_W-1:0]       wait_cnt;
  logic                    deep_sleep;
  logic [1:0]              half_cnt;
  logic [NCH*WORD_W-1:0]   pipe [PIPE_D];
  logic [OUT_DELAY_CLKS-1:0] ev_rise;
  logic [OUT_DELAY_CLKS-1:0] ev_fall;
  logic [WORD_W-1:0]       code [NCH];
  logic                    capture_en;
  logic                    overrun;
  logic [ADDR_W-1:0]       wr_addr;
  logic [31:0]             wr_data;
  logic [3:0]              wr_strb;

  dadc_fifo_if #(.WIDTH(FIFO_W)) ff_link ();

  dadc_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk   (clk),
    .ce    (ce),
    .rst_b (rst_b),
    .port  (ff_link.fifo)
  );

  // Per-channel range scaling and saturation
  wire signed [IN_W-1:0] ch_in [NCH];
  assign ch_in[0] = first_analog_in;
  assign ch_in[1] = second_analog_in;

  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_ch
      wire signed [IN_W-1:0] scaled = range_select_pin ? (ch_in[g] >>> 1) : ch_in[g];
      assign code[g] = (scaled > LIM_POS) ? POS_FS :
                       (scaled < LIM_NEG) ? NEG_FS : scaled[WORD_W-1:0];
    end
  endgenerate

  // Power sequencing
  wire sleep_req = power_down_pin || standby_pin;
  wire conv_on   = st != ST_OFF;
  wire [WAIT_W-1:0] wait_last = deep_sleep ? DEEP_LAST : STANDBY_LAST;

  always_comb
  begin
    next_st = st;
    case (st)
      ST_OFF:  if (!sleep_req) next_st = ST_WAKE;
      ST_WAKE:
      begin
        if (sleep_req)
          next_st = ST_OFF;
        else if (wait_cnt == wait_last)
          next_st = ST_RUN;
      end
      ST_RUN:  if (sleep_req) next_st = ST_OFF;
      default: next_st = ST_OFF;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      st <= ST_OFF;
    else if (ce)
      st <= next_st;
  end

  // Power-down is remembered so the longer wake applies
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      deep_sleep <= 1'b1;
      wait_cnt   <= '0;
    end
    else if (ce)
    begin
      if (st == ST_OFF)
        deep_sleep <= deep_sleep || power_down_pin;
      else if (next_st == ST_RUN)
        deep_sleep <= 1'b0;
      wait_cnt <= (st == ST_WAKE) ? wait_cnt + 1'b1 : '0;
    end
  end

  // Sampling clock divider; frozen while asleep
  wire tick      = conv_on && (half_cnt == HALF_LAST);
  wire fall_tick = tick && sample_clock;
  wire rise_tick = tick && !sample_clock;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      half_cnt     <= 2'h0;
      sample_clock <= 1'b0;
    end
    else if (ce && conv_on)
    begin
      half_cnt <= tick ? 2'h0 : half_cnt + 2'h1;
      if (tick)
        sample_clock <= !sample_clock;
    end
  end

  // Half-period pipeline; entry k holds a sample k edges old
  generate
    for (g = 0; g < PIPE_D; g++)
    begin : g_pipe
      if (g == 0)
      begin : g_head
        always_ff @(posedge clk or negedge rst_b)
        begin
          if (!rst_b)
            pipe[g] <= '0;
          else if (ce && fall_tick)
            pipe[g] <= {code[1], code[0]};
        end
      end
      else
      begin : g_tail
        always_ff @(posedge clk or negedge rst_b)
        begin
          if (!rst_b)
            pipe[g] <= '0;
          else if (ce && tick)
            pipe[g] <= pipe[g-1];
        end
      end
    end
  endgenerate

  // Output delay line after each sampling edge; oldest bit drops off the top
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ev_rise <= '0;
      ev_fall <= '0;
    end
    else if (ce)
    begin
      ev_rise <= OUT_DELAY_CLKS'({ev_rise, rise_tick});
      ev_fall <= OUT_DELAY_CLKS'({ev_fall, fall_tick});
    end
  end

  wire rise_out = ev_rise[OUT_DELAY_CLKS-1];
  wire fall_out = ev_fall[OUT_DELAY_CLKS-1];
  wire parallel = output_mode_select;
  wire [WORD_W-1:0] word_i = pipe[LAT_HALVES_I][WORD_W-1:0];
  wire [WORD_W-1:0] word_q = pipe[LAT_HALVES_Q][2*WORD_W-1:WORD_W];

  // Output buses; limitation: delay must stay below a half period
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      first_channel_output_bus  <= '0;
      second_channel_output_bus <= '0;
      channel_select_strobe     <= 1'b0;
    end
    else if (ce && rise_out)
    begin
      first_channel_output_bus  <= word_i;
      second_channel_output_bus <= parallel ? pipe[LAT_HALVES_I][2*WORD_W-1:WORD_W] : '0;
      channel_select_strobe     <= !parallel;
    end
    else if (ce && fall_out && !parallel)
    begin
      first_channel_output_bus <= word_q;
      channel_select_strobe    <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      conversion_settled <= 1'b0;
    else if (ce)
      conversion_settled <= next_st == ST_RUN;
  end

  // Buffer fill; words from the wake interval are not kept
  wire push_try  = rise_out && conversion_settled && capture_en;
  wire push_drop = push_try && !ff_link.in_ready;
  assign ff_link.in_valid = push_try;
  assign ff_link.in_data  = pipe[LAT_HALVES_I];

  // AXI4-Lite write channel
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take  = s_axi_wvalid && s_axi_wready;
  wire b_take  = s_axi_bvalid && s_axi_bready;
  wire wr_do   = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire wr_ctrl = wr_do && wr_addr == OFF_CTRL && wr_strb[0];
  wire wr_stat = wr_do && wr_addr == OFF_STATUS && wr_strb[0];
  wire wr_map  = wr_addr == OFF_CTRL || wr_addr == OFF_STATUS || wr_addr == OFF_DATA;
  wire ovr_clr = wr_stat && wr_data[STAT_OVERRUN];

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      wr_addr       <= '0;
      wr_data       <= '0;
      wr_strb       <= '0;
    end
    else if (ce)
    begin
      if (aw_take)
        wr_addr <= s_axi_awaddr;
      if (w_take)
      begin
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      s_axi_awready <= b_take || (s_axi_awready && !aw_take);
      s_axi_wready  <= b_take || (s_axi_wready && !w_take);
      if (wr_do)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end
      else if (b_take)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Control and sticky overrun; a new drop beats a clear
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      capture_en <= CTRL_CAPTURE_RST;
      overrun    <= 1'b0;
    end
    else if (ce)
    begin
      if (wr_ctrl)
        capture_en <= wr_data[CTRL_CAPTURE_BIT];
      overrun <= push_drop || (overrun && !ovr_clr);
    end
  end

  // AXI4-Lite read channel; reading the data word pops the buffer
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire r_take  = s_axi_rvalid && s_axi_rready;
  wire rd_data_hit = s_axi_araddr == OFF_DATA;
  wire rd_map  = s_axi_araddr == OFF_CTRL || s_axi_araddr == OFF_STATUS || rd_data_hit;
  wire [31:0] stat_word = 32'(
    {overrun, !ff_link.in_ready, !ff_link.out_valid, conv_on, conversion_settled});
  wire [31:0] ctrl_word = 32'(capture_en);
  wire [31:0] data_word = ff_link.out_valid ?
    {6'h00, ff_link.out_data[2*WORD_W-1:WORD_W], 6'h00, ff_link.out_data[WORD_W-1:0]} : 32'h0;
  wire [31:0] rd_mux = (s_axi_araddr == OFF_CTRL)   ? ctrl_word :
                       (s_axi_araddr == OFF_STATUS) ? stat_word :
                       rd_data_hit                  ? data_word : 32'h0;
  assign ff_link.out_ready = ar_take && rd_data_hit;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end
    else if (ce)
    begin
      if (ar_take)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_mux;
        s_axi_rresp   <= rd_map ? RESP_OKAY : RESP_SLVERR;
      end
      else if (r_take)
      begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b0;
      end
    end
  end

  // Checks; age counts cycles of unbroken conversion with ce high
  logic [3:0] age;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      age <= 4'h0;
    else
      age <= (!ce || !conv_on) ? 4'h0 : ((age == 4'hF) ? age : age + 4'h1);
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_sample_both: assert property (ce && fall_tick |=>
    pipe[0] == {$past(code[1]), $past(code[0])})
    else $error("sample pair not taken on falling edge");
  a_rate_limit: assert property (ce && tick |=> !tick)
    else $error("sampling edges too close");
  a_par_pair: assert property (ce && rise_out && parallel && age == 4'hF |=>
    second_channel_output_bus == $past(code[1], LAT_I_CLKS) && !channel_select_strobe)
    else $error("parallel second bus wrong");
  a_par_latency: assert property (ce && rise_out && parallel && age == 4'hF |=>
    first_channel_output_bus == $past(code[0], LAT_I_CLKS))
    else $error("parallel latency wrong");
  a_mux_first: assert property (ce && rise_out && !parallel && age == 4'hF |=>
    first_channel_output_bus == $past(code[0], LAT_I_CLKS) && channel_select_strobe)
    else $error("multiplexed first word wrong");
  a_mux_second: assert property (ce && fall_out && !parallel && age == 4'hF |=>
    first_channel_output_bus == $past(code[1], LAT_Q_CLKS) && !channel_select_strobe)
    else $error("multiplexed second word wrong");
  a_every_cycle: assert property (rise_tick ##1 (ce && conv_on)[*4] |-> rise_tick)
    else $error("result cadence broken");
  a_sleep_stop: assert property (ce && sleep_req |=> st == ST_OFF && !tick)
    else $error("converting while asleep");
  a_neg_clamp: assert property (!range_select_pin && second_analog_in < LIM_NEG |->
    code[1] == NEG_FS)
    else $error("negative clamp missing");
  a_pos_clamp: assert property (range_select_pin && first_analog_in > 12'sh3FF |->
    code[0] == POS_FS)
    else $error("positive clamp missing");
  a_span_double: assert property (range_select_pin && first_analog_in == 12'sh2FE |->
    code[0] == 10'h17F)
    else $error("range doubling wrong");
  a_standby_wake: assert property (ce && st == ST_WAKE && !deep_sleep && !sleep_req
    && wait_cnt == STANDBY_LAST |=> conversion_settled)
    else $error("standby wake too slow");
  a_deep_wake: assert property ($rose(conversion_settled) && $past(deep_sleep) |->
    $past(wait_cnt) == DEEP_LAST)
    else $error("power-down wake length wrong");
  a_wake_quiet: assert property (st != ST_RUN |-> !push_try)
    else $error("waking word buffered");

  c_mux_second: cover property (fall_out && !parallel && age == 4'hF);
  c_par_word: cover property (rise_out && parallel && age == 4'hF);
  c_overrun: cover property (push_drop);
  c_wake_done: cover property ($rose(conversion_settled));
endmodule
